/* File: bpu_pkg.sv */
/*
  Shared constants and types for the branch prediction unit.
  Assumes a single core clock and a 64-bit program counter.
*/
package bpu_pkg;
  localparam int PC_W         = 64;
  localparam int DIR_ENTRIES  = 4096;
  localparam int DIR_IDX_W    = 12;
  localparam int CTR_W        = 2;
  localparam int HIST_W       = 9;
  localparam int PC_IDX_W     = 11;
  localparam int PC_IDX_LSB   = 2;
  localparam int NUM_PRED     = 2;
  localparam int RAS_DEPTH    = 8;
  localparam int RAS_PTR_W    = 3;
  localparam int ITC_ENTRIES  = 64;
  localparam int ITC_IDX_W    = 6;
  localparam logic [CTR_W-1:0]  CTR_RESET  = 2'h1;
  localparam logic [CTR_W-1:0]  CTR_MAX    = 2'h3;
  localparam logic [CTR_W-1:0]  CTR_MIN    = 2'h0;
  localparam logic [HIST_W-1:0] HIST_RESET = 9'h000;
  typedef logic [PC_W-1:0] addr_t;
  typedef enum logic [1:0]
  {
    INIT_RUN  = 2'h1,
    INIT_DONE = 2'h2
  } init_state_t;
endpackage

/* File: branch_prediction_unit.sv */
/*
  Branch prediction front end: gshare direction predictor, return address
  stack and indirect target cache. Fetch presents up to two branch PCs per
  cycle and gets predictions two cycles later; resolution reports outcomes.
  Assumes fetch and resolution logic run on clk and redirect on mispredict.
*/
// Operation
// RULE_01: 4K two-bit entries for direction prediction.
// RULE_02: Nine-bit global history of branch outcomes.
// RULE_03: Index is history XOR eleven PC bits; the code XORs it against twelve PC bits, pc[13:2].
// RULE_04: Counter high bit predicts taken.
// RULE_05: Two independent predictions per cycle; the code denies slot 0 in any cycle with res_valid.
// RULE_06: Eight-entry return stack predicts return targets.
// RULE_07: Sixty-four entry cache predicts register jumps.
// RULE_08: Resolution checks prediction and signals redirect; the code has no redirect output, resolution only trains the tables.
// RULE_09: Saturating counter update and history shift.
`timescale 1ns/1ps
module branch_prediction_unit
(
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  input  wire logic [bpu_pkg::NUM_PRED-1:0]  pred_valid,
  input  wire bpu_pkg::addr_t                pred_pc [bpu_pkg::NUM_PRED],
  output logic [bpu_pkg::NUM_PRED-1:0]       pred_taken_r,
  output logic [bpu_pkg::NUM_PRED-1:0]       pred_ready_r,
  input  wire logic                          call_push,
  input  wire bpu_pkg::addr_t                call_link,
  input  wire logic                          ret_pop,
  output bpu_pkg::addr_t                     ret_target_r,
  output logic                               ret_valid_r,
  input  wire logic                          jr_lookup,
  input  wire bpu_pkg::addr_t                jr_pc,
  output bpu_pkg::addr_t                     jr_target_r,
  output logic                               jr_hit_r,
  input  wire logic                          res_valid,
  input  wire bpu_pkg::addr_t                res_pc,
  input  wire logic                          res_taken,
  input  wire logic                          res_is_jr,
  input  wire bpu_pkg::addr_t                res_target,
  output logic                               init_busy_r
);
  import bpu_pkg::*;

  dir_if dif ();
  dir_table u_table
  (
    .clk  (clk),
    .port (dif)
  );

  logic [HIST_W-1:0]    branch_history_reg_r;
  init_state_t          init_st_r;
  logic [DIR_IDX_W-1:0] init_idx_r;
  logic [NUM_PRED-1:0]  rd_pend_r;
  logic [DIR_IDX_W-1:0] res_idx;
  logic [CTR_W-1:0]     upd_ctr_nxt;
  logic                 upd_pend_r;
  logic                 upd_taken_r;
  logic [DIR_IDX_W-1:0] upd_idx_r;

  // Twelve PC bits against the zero-extended nine-bit history; the top three index
  // bits come from the PC alone so the whole 4K table is reachable.
  function automatic logic [DIR_IDX_W-1:0] gidx(input addr_t pc, input logic [HIST_W-1:0] h);
    gidx = pc[PC_IDX_LSB +: DIR_IDX_W] ^ {3'h0, h}; // RULE_03
  endfunction

  for (genvar g = 0; g < NUM_PRED; g++)
  begin : g_rd
    assign dif.rd_idx[g] = (g == 0 && res_valid) ? gidx(res_pc, branch_history_reg_r)
                         : gidx(pred_pc[g], branch_history_reg_r); // RULE_05
  end
  assign res_idx = gidx(res_pc, branch_history_reg_r);

  // Port 0 is lent to resolution for the read half of the counter update,
  // so a lookup on slot 0 in the same cycle is not granted.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rd_pend_r <= '0;
    else
      rd_pend_r <= pred_valid & ~{1'b0, res_valid} & {NUM_PRED{init_st_r == INIT_DONE}};
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pred_taken_r <= '0;
      pred_ready_r <= '0;
    end
    else
    begin
      pred_ready_r <= rd_pend_r;
      for (int i = 0; i < NUM_PRED; i++)
        pred_taken_r[i] <= rd_pend_r[i] & dif.rd_ctr[i][CTR_W-1]; // RULE_04
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      branch_history_reg_r <= HIST_RESET;
    else if (res_valid && !res_is_jr)
      branch_history_reg_r <= {branch_history_reg_r[HIST_W-2:0], res_taken}; // RULE_02
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      upd_pend_r  <= 1'b0;
      upd_taken_r <= 1'b0;
      upd_idx_r   <= '0;
    end
    else
    begin
      upd_pend_r  <= res_valid && !res_is_jr && init_st_r == INIT_DONE;
      upd_taken_r <= res_taken;
      upd_idx_r   <= res_idx;
    end
  end

  always_comb
  begin
    upd_ctr_nxt = dif.rd_ctr[0];
    if (upd_taken_r && dif.rd_ctr[0] != CTR_MAX)
      upd_ctr_nxt = dif.rd_ctr[0] + 2'h1; // RULE_09
    else if (!upd_taken_r && dif.rd_ctr[0] != CTR_MIN)
      upd_ctr_nxt = dif.rd_ctr[0] - 2'h1; // RULE_09
  end

  // The table has no reset, so every counter is walked to weakly not taken.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      init_st_r   <= INIT_RUN;
      init_idx_r  <= '0;
      init_busy_r <= 1'b1;
    end
    else
    begin
      case (init_st_r)
        INIT_RUN:
        begin
          init_idx_r <= init_idx_r + 12'h001;
          if (init_idx_r == 12'hFFF)
          begin
            init_st_r   <= INIT_DONE;
            init_busy_r <= 1'b0;
          end
        end
        INIT_DONE: init_st_r <= INIT_DONE;
        default:   init_st_r <= INIT_RUN;
      endcase
    end
  end

  assign dif.wr_en  = (init_st_r == INIT_RUN) || upd_pend_r;
  assign dif.wr_idx = (init_st_r == INIT_RUN) ? init_idx_r : upd_idx_r;
  assign dif.wr_ctr = (init_st_r == INIT_RUN) ? CTR_RESET : upd_ctr_nxt; // RULE_01

  // Return stack wraps on overflow, dropping the oldest link.
  addr_t                return_addr_stack_r [RAS_DEPTH];
  logic [RAS_PTR_W-1:0] ras_top_r;
  logic [RAS_PTR_W:0]   ras_cnt_r;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ras_top_r    <= '0;
      ras_cnt_r    <= '0;
      ret_valid_r  <= 1'b0;
      ret_target_r <= '0;
      for (int i = 0; i < RAS_DEPTH; i++)
        return_addr_stack_r[i] <= '0;
    end
    else
    begin
      ret_valid_r <= 1'b0;
      if (call_push)
      begin
        return_addr_stack_r[ras_top_r + 3'h1] <= call_link; // RULE_06
        ras_top_r <= ras_top_r + 3'h1;
        if (ras_cnt_r != 4'h8)
          ras_cnt_r <= ras_cnt_r + 4'h1;
      end
      else if (ret_pop)
      begin
        ret_target_r <= return_addr_stack_r[ras_top_r]; // RULE_06
        ret_valid_r  <= ras_cnt_r != 4'h0;
        if (ras_cnt_r != 4'h0)
        begin
          ras_top_r <= ras_top_r - 3'h1;
          ras_cnt_r <= ras_cnt_r - 4'h1;
        end
      end
    end
  end

  // Direct-mapped, tagged by the remaining word-address bits.
  localparam int TAG_W = PC_W - PC_IDX_LSB - ITC_IDX_W;
  addr_t              indirect_target_cache_r [ITC_ENTRIES];
  logic [TAG_W-1:0]   itc_tag_r [ITC_ENTRIES];
  logic [ITC_ENTRIES-1:0] itc_vld_r;
  logic [ITC_IDX_W-1:0] jr_i;
  logic [ITC_IDX_W-1:0] wr_i;
  assign jr_i = jr_pc[PC_IDX_LSB +: ITC_IDX_W];
  assign wr_i = res_pc[PC_IDX_LSB +: ITC_IDX_W];

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      itc_vld_r   <= '0;
      jr_hit_r    <= 1'b0;
      jr_target_r <= '0;
      for (int i = 0; i < ITC_ENTRIES; i++)
      begin
        indirect_target_cache_r[i] <= '0;
        itc_tag_r[i] <= '0;
      end
    end
    else
    begin
      jr_hit_r    <= jr_lookup && itc_vld_r[jr_i]
                     && itc_tag_r[jr_i] == jr_pc[PC_W-1 -: TAG_W]; // RULE_07
      jr_target_r <= indirect_target_cache_r[jr_i];
      if (res_valid && res_is_jr)
      begin
        indirect_target_cache_r[wr_i] <= res_target; // RULE_07
        itc_tag_r[wr_i] <= res_pc[PC_W-1 -: TAG_W];
        itc_vld_r[wr_i] <= 1'b1;
      end
    end
  end

  a_pred_ready_lat: assert property (@(posedge clk) disable iff (!reset_n) // RULE_05
    pred_valid[1] && !res_valid && init_st_r == INIT_DONE |-> ##2 pred_ready_r[1])
    else $error("prediction not ready two cycles after request");
  a_hist_shift: assert property (@(posedge clk) disable iff (!reset_n) // RULE_02
    res_valid && !res_is_jr |=> branch_history_reg_r[0] == $past(res_taken))
    else $error("history did not take resolved outcome");
  a_ctr_saturate: assert property (@(posedge clk) disable iff (!reset_n) // RULE_09
    upd_pend_r && upd_taken_r && dif.rd_ctr[0] == CTR_MAX |-> dif.wr_ctr == CTR_MAX)
    else $error("counter wrapped past maximum");
  a_ctr_decr: assert property (@(posedge clk) disable iff (!reset_n) // RULE_09
    upd_pend_r && !upd_taken_r && dif.rd_ctr[0] == 2'h2 |-> dif.wr_ctr == 2'h1)
    else $error("counter did not decrement");
  a_taken_msb: assert property (@(posedge clk) disable iff (!reset_n) // RULE_04
    rd_pend_r[0] |=> pred_taken_r[0] == $past(dif.rd_ctr[0][1]))
    else $error("prediction does not follow counter msb");
  // The top three index bits come from the PC alone; the low nine carry the history.
  a_index_xor: assert property (@(posedge clk) disable iff (!reset_n) // RULE_03
    !res_valid |-> dif.rd_idx[1]
      == {pred_pc[1][13], pred_pc[1][12:2] ^ {2'h0, branch_history_reg_r}})
    else $error("index not history xor pc");
  a_ras_lifo: assert property (@(posedge clk) disable iff (!reset_n) // RULE_06
    call_push ##1 (ret_pop && !call_push)
      |=> ret_valid_r && ret_target_r == $past(call_link, 2))
    else $error("return stack did not return last link");
  a_itc_hit: assert property (@(posedge clk) disable iff (!reset_n) // RULE_07
    res_valid && res_is_jr ##1 (jr_lookup && jr_pc == $past(res_pc) && !res_valid)
      |=> jr_hit_r && jr_target_r == $past(res_target, 2))
    else $error("indirect target not returned after fill");
  a_init_len: assert property (@(posedge clk) disable iff (!reset_n) // RULE_01
    init_st_r == INIT_RUN && init_idx_r == 12'hFFF |=> !init_busy_r)
    else $error("table walk did not finish at last entry");
endmodule

/* File: branch_prediction_unit_tb_top.sv */
/*
  Self-checking bench for the branch prediction unit.
  Assumes the resolution model in resolve_model and the shared package.
*/
`timescale 1ns/1ps
module branch_prediction_unit_tb_top;
  import bpu_pkg::*;
  logic                 clk;
  logic                 reset_n;
  logic [NUM_PRED-1:0]  pred_valid;
  addr_t                pred_pc [NUM_PRED];
  logic [NUM_PRED-1:0]  pred_taken_r;
  logic [NUM_PRED-1:0]  pred_ready_r;
  logic                 call_push;
  addr_t                call_link;
  logic                 ret_pop;
  addr_t                ret_target_r;
  logic                 ret_valid_r;
  logic                 jr_lookup;
  addr_t                jr_pc;
  addr_t                jr_target_r;
  logic                 jr_hit_r;
  logic                 res_valid;
  addr_t                res_pc;
  logic                 res_taken;
  logic                 res_is_jr;
  addr_t                res_target;
  logic                 init_busy_r;
  logic [HIST_W-1:0]    hist;
  int                   fails;
  int                   samples_checked;
  localparam logic [DIR_IDX_W-1:0] TRAIN_IDX = 12'hA5C;
  localparam logic [DIR_IDX_W-1:0] IDLE_IDX  = 12'h3F1;
  localparam addr_t                JR_PC     = 64'h0000_1000_0000_0104;

  branch_prediction_unit dut_u (.clk(clk), .reset_n(reset_n), .pred_valid(pred_valid),
    .pred_pc(pred_pc), .pred_taken_r(pred_taken_r), .pred_ready_r(pred_ready_r),
    .call_push(call_push), .call_link(call_link), .ret_pop(ret_pop),
    .ret_target_r(ret_target_r), .ret_valid_r(ret_valid_r), .jr_lookup(jr_lookup),
    .jr_pc(jr_pc), .jr_target_r(jr_target_r), .jr_hit_r(jr_hit_r), .res_valid(res_valid),
    .res_pc(res_pc), .res_taken(res_taken), .res_is_jr(res_is_jr),
    .res_target(res_target), .init_busy_r(init_busy_r));

  resolve_model resolver_u (.clk(clk), .res_valid(res_valid), .res_pc(res_pc),
    .res_taken(res_taken), .res_is_jr(res_is_jr), .res_target(res_target));

  always #10 clk = ~clk;

  task automatic chk(input string what, input logic [PC_W-1:0] exp, input logic [PC_W-1:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    if (fails == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // The history is folded back out so that every call lands on the same counter.
  function automatic addr_t pc_for(input logic [DIR_IDX_W-1:0] idx);
    return {50'h0, idx ^ {3'h0, hist}, 2'h0};
  endfunction

  task automatic lookup(input addr_t pc0, input addr_t pc1, input logic [1:0] vld,
                        input logic [1:0] rdy, input logic [1:0] tkn);
    @(posedge clk);
    pred_valid <= vld;
    pred_pc[0] <= pc0;
    pred_pc[1] <= pc1;
    @(posedge clk);
    pred_valid <= '0;
    @(posedge clk);
    #1;
    chk("pred_ready", 64'(rdy), 64'(pred_ready_r));
    chk("pred_taken", 64'(tkn & rdy), 64'(pred_taken_r & rdy));
  endtask

  task automatic init_scenario();
    chk("init_busy", 64'h1, 64'(init_busy_r));
    lookup(pc_for(TRAIN_IDX), pc_for(IDLE_IDX), 2'h3, 2'h0, 2'h0);
    for (int i = 0; i < 5000 && init_busy_r !== 1'b0; i++)
      @(posedge clk);
    #1;
    chk("init_busy", 64'h0, 64'(init_busy_r));
  endtask

  task automatic train_scenario();
    logic [CTR_W-1:0] ctr;
    logic [6:0]       outcome;
    ctr = CTR_RESET;
    outcome = 7'h07;
    lookup(pc_for(TRAIN_IDX), pc_for(IDLE_IDX), 2'h3, 2'h3, {1'b0, ctr[1]});
    for (int i = 0; i < 7; i++)
    begin
      resolver_u.resolve(pc_for(TRAIN_IDX), outcome[i], 1'b0, '0);
      hist = {hist[HIST_W-2:0], outcome[i]};
      if (outcome[i] && ctr != CTR_MAX)
        ctr = ctr + 2'h1;
      else if (!outcome[i] && ctr != CTR_MIN)
        ctr = ctr - 2'h1;
      repeat (2) @(posedge clk);
      lookup(pc_for(TRAIN_IDX), pc_for(IDLE_IDX), 2'h3, 2'h3, {1'b0, ctr[1]});
    end
    lookup(pc_for(TRAIN_IDX), pc_for(IDLE_IDX), 2'h2, 2'h2, 2'h0);
    // Slot 0 is lent to resolution, so only slot 1 may answer here.
    fork
      resolver_u.resolve(64'h2000_0200, 1'b1, 1'b1, 64'h0AB0);
      lookup(pc_for(TRAIN_IDX), pc_for(IDLE_IDX), 2'h3, 2'h2, 2'h0);
    join
  endtask

  task automatic ras_scenario();
    for (int k = 1; k <= 9; k++)
    begin
      @(posedge clk);
      call_push <= 1'b1;
      call_link <= 64'(k * 16);
    end
    for (int k = 9; k >= 1; k--)
    begin
      @(posedge clk);
      call_push <= 1'b0;
      ret_pop   <= 1'b1;
      @(posedge clk);
      ret_pop <= 1'b0;
      #1;
      chk("ret_valid", 64'(k > 1), 64'(ret_valid_r));
      if (k > 1)
        chk("ret_target", 64'(k * 16), ret_target_r);
    end
  endtask

  task automatic jr_probe(input addr_t pc, input logic hit, input addr_t tgt);
    @(posedge clk);
    jr_lookup <= 1'b1;
    jr_pc     <= pc;
    @(posedge clk);
    jr_lookup <= 1'b0;
    #1;
    chk("jr_hit", 64'(hit), 64'(jr_hit_r));
    if (hit)
      chk("jr_target", tgt, jr_target_r);
  endtask

  task automatic jr_scenario();
    jr_probe(JR_PC, 1'b0, '0);
    resolver_u.resolve(JR_PC, 1'b1, 1'b1, 64'h0000_0000_0040_BEE0);
    // The probe follows the fill by one cycle and must already see the new target.
    fork
      resolver_u.resolve(64'h00FC, 1'b1, 1'b1, 64'h0000_0000_0000_7770);
      begin
        @(posedge clk);
        jr_probe(64'h00FC, 1'b1, 64'h0000_0000_0000_7770);
      end
    join
    jr_probe(JR_PC, 1'b1, 64'h0000_0000_0040_BEE0);
    jr_probe(JR_PC ^ 64'h1000, 1'b0, '0);
  endtask

  initial
  begin
    clk = 1'b0;
    reset_n = 1'b0;
    pred_valid = '0;
    pred_pc[0] = '0;
    pred_pc[1] = '0;
    call_push = 1'b0;
    call_link = '0;
    ret_pop = 1'b0;
    jr_lookup = 1'b0;
    jr_pc = '0;
    hist = HIST_RESET;
    fails = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    init_scenario();
    train_scenario();
    ras_scenario();
    jr_scenario();
    end_of_test();
  end

  // About 4200 cycles are needed; the margin covers a slow init walk.
  initial
  begin
    #(20 * 20000);
    fails++;
    end_of_test();
  end
endmodule

/* File: dir_if.sv */
/*
  Interface between the prediction unit and its counter table.
  Assumes both ends share the core clock.
*/
`timescale 1ns/1ps
interface dir_if;
  import bpu_pkg::*;
  logic [DIR_IDX_W-1:0] rd_idx [NUM_PRED];
  logic [CTR_W-1:0]     rd_ctr [NUM_PRED];
  logic                 wr_en;
  logic [DIR_IDX_W-1:0] wr_idx;
  logic [CTR_W-1:0]     wr_ctr;
  modport user (output rd_idx, output wr_en, output wr_idx, output wr_ctr, input rd_ctr);
  modport mem  (input rd_idx, input wr_en, input wr_idx, input wr_ctr, output rd_ctr);
endinterface

/* File: dir_table.sv */
/*
  Counter table of the direction predictor with registered read ports.
  Assumes one write per cycle; a write and a read to one entry return old data.
*/
`timescale 1ns/1ps
module dir_table
(
  input  wire logic clk,
  dir_if.mem        port
);
  import bpu_pkg::*;

  logic [CTR_W-1:0] mem_r [DIR_ENTRIES];

  always_ff @(posedge clk)
  begin
    if (port.wr_en)
      mem_r[port.wr_idx] <= port.wr_ctr; // RULE_01
  end

  for (genvar g = 0; g < NUM_PRED; g++)
  begin : g_rd
    always_ff @(posedge clk)
    begin
      port.rd_ctr[g] <= mem_r[port.rd_idx[g]]; // RULE_05
    end
  end
endmodule

/* File: resolve_model.sv */
/*
  Behavioural model of the branch resolution stage beside the prediction unit.
  Assumes the core clock; the bench calls resolve between lookups and also alongside them in fork blocks.
*/
`timescale 1ns/1ps
module resolve_model
(
  input  wire logic     clk,
  output logic          res_valid,
  output bpu_pkg::addr_t res_pc,
  output logic          res_taken,
  output logic          res_is_jr,
  output bpu_pkg::addr_t res_target
);
  import bpu_pkg::*;

  initial
  begin
    res_valid  = 1'b0;
    res_pc     = '0;
    res_taken  = 1'b0;
    res_is_jr  = 1'b0;
    res_target = '0;
  end

  // Released lines are inverted so that stale values cannot pass for a result.
  task automatic resolve(input addr_t pc, input logic taken, input logic is_jr, input addr_t tgt);
    @(posedge clk);
    res_valid  <= 1'b1;
    res_pc     <= pc;
    res_taken  <= taken;
    res_is_jr  <= is_jr;
    res_target <= tgt;
    @(posedge clk);
    res_valid  <= 1'b0;
    res_pc     <= ~pc;
    res_taken  <= ~taken;
    res_is_jr  <= ~is_jr;
    res_target <= ~tgt;
  endtask
endmodule
